// ===== design/sfr_bank1_decode.sv
// Bank-one special-function register decoder with indirect access and port read gating
`timescale 1ns/1ps
`include "sfr_bank1_decode_defines.svh"

module sfr_bank1_decode (
	// Clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       rst_n_i,
	// Reset cause, valid while rst_n_i is low
	input  wire logic       reset_por_i,
	input  wire logic       reset_bor_i,
	// Register port
	input  wire logic [7:0] addr_i,
	input  wire logic [7:0] wr_data_i,
	input  wire logic       wr_en_i,
	input  wire logic       rd_en_i,
	output logic      [7:0] rd_data_o,
	// Data memory reached through the pointer
	output logic      [8:0] dmem_addr_o,
	output logic      [7:0] dmem_wdata_o,
	output logic            dmem_we_o,
	output logic            dmem_re_o,
	input  wire logic [7:0] dmem_rdata_i,
	// Peripheral-owned status bits
	input  wire logic       timeout_flag_i,
	input  wire logic       powerdown_flag_i,
	input  wire logic [2:0] osc_status_i,
	input  wire logic [5:0] serial_status_i,
	// Port pins
	input  wire logic [7:0] port_a_pins_i,
	input  wire logic [7:0] port_b_pins_i,
	input  wire logic [7:0] port_c_pins_i,
	input  wire logic [7:0] port_d_pins_i,
	input  wire logic [7:0] port_e_pins_i,
	// Configuration to the core and peripherals
	output logic      [7:0] port_a_direction_o,
	output logic      [7:0] port_b_direction_o,
	output logic      [7:0] port_c_direction_o,
	output logic      [7:0] port_d_direction_o,
	output logic      [7:0] port_e_direction_o,
	output logic      [7:0] port_a_latch_o,
	output logic      [7:0] port_b_latch_o,
	output logic      [7:0] port_c_latch_o,
	output logic      [7:0] port_d_latch_o,
	output logic      [7:0] port_e_latch_o,
	output logic      [7:0] port_b_weak_pullup_o,
	output logic      [7:0] prescaler_edge_config_o,
	output logic      [7:0] interrupt_control_o,
	output logic      [7:0] timer2_period_o,
	output logic      [7:0] serial_slave_address_o,
	output logic      [7:0] serial_address_mask_o,
	output logic      [3:0] serial_port_mode_field_o,
	// Interrupt
	output logic            irq_o
);

	sfr_bank1_decode_pkg::state_type state_q;
	sfr_bank1_decode_pkg::state_type state_d;

	logic [7:0] port_b_digital;
	logic       mismatch;
	logic       flag_now;
	logic       mask_access;
	logic       wr_indirect;
	logic       rd_indirect;

	// Analog-selected pins read as zero, no matter what the pad shows
	function automatic logic [7:0] port_read(input logic [7:0] pins, input logic [7:0] analog);
		port_read = pins & ~analog;
	endfunction

	// The mode field decides which register answers at the shared offset
	function automatic logic is_mask_access(input logic [7:0] ctrl);
		is_mask_access = (ctrl[3:0] == `SERIAL_MODE_MASK_ACCESS);
	endfunction

	assign mask_access = is_mask_access(state_q.serial_port_control);
	assign wr_indirect = wr_en_i && (addr_i == `OFS_INDIRECT_ACCESS_PORT);
	assign rd_indirect = rd_en_i && (addr_i == `OFS_INDIRECT_ACCESS_PORT);

	// No storage at the indirect offset; the access goes straight to memory
	assign dmem_addr_o  = {state_q.alu_flags_bank_select[`BIT_INDIRECT_BANK], state_q.indirect_pointer};
	assign dmem_wdata_o = wr_data_i;
	assign dmem_we_o    = wr_indirect;
	assign dmem_re_o    = rd_indirect;

	// Change detection only on digital pins, so an analog pin cannot raise the flag
	assign port_b_digital = port_read(port_b_pins_i, state_q.analog_select_high);
	assign mismatch       = (port_b_digital != state_q.port_b_snapshot);

	always_comb
	begin
		state_d  = state_q;
		flag_now = state_q.interrupt_control[`BIT_PORT_B_CHANGE_FLAG];

		// Register writes; bits that are not implemented are masked off
		if (wr_en_i)
		begin
			case (addr_i)
				`OFS_PRESCALER_EDGE_CONFIG: state_d.prescaler_edge_config = wr_data_i;
				`OFS_PROGRAM_COUNTER_LOW:   state_d.program_counter_low = wr_data_i;
				`OFS_ALU_FLAGS_BANK_SELECT: state_d.alu_flags_bank_select = wr_data_i & `MSK_ALU_FLAGS_WR;
				`OFS_INDIRECT_POINTER:      state_d.indirect_pointer = wr_data_i;
				`OFS_PORT_A_DIRECTION:      state_d.port_a_direction = wr_data_i;
				`OFS_PORT_B_DIRECTION:      state_d.port_b_direction = wr_data_i;
				`OFS_PORT_C_DIRECTION:      state_d.port_c_direction = wr_data_i;
				`OFS_PORT_D_DIRECTION:      state_d.port_d_direction = wr_data_i;
				`OFS_PORT_E_DIRECTION:      state_d.port_e_direction = wr_data_i & `MSK_PORT_E;
				`OFS_PC_HIGH_LATCH:         state_d.program_counter_high_latch = wr_data_i & `MSK_PC_HIGH_LATCH;
				`OFS_INTERRUPT_CONTROL:     state_d.interrupt_control = wr_data_i;
				`OFS_PERIPH_IRQ_ENABLE_1:   state_d.peripheral_irq_enable_1 = wr_data_i & `MSK_PERIPH_IRQ_ENABLE_1;
				`OFS_PERIPH_IRQ_ENABLE_2:   state_d.peripheral_irq_enable_2 = wr_data_i & `MSK_PERIPH_IRQ_ENABLE_2;
				`OFS_POWER_CONTROL:         state_d.power_control = wr_data_i & `MSK_POWER_CONTROL;
				`OFS_OSCILLATOR_CONTROL:    state_d.oscillator_control = wr_data_i & `MSK_OSCILLATOR_CONTROL_WR;
				`OFS_OSCILLATOR_TUNING:     state_d.oscillator_tuning = wr_data_i & `MSK_OSCILLATOR_TUNING;
				`OFS_SERIAL_PORT_CONTROL_2: state_d.serial_port_control_2 = wr_data_i;
				`OFS_TIMER2_PERIOD:         state_d.timer2_period = wr_data_i;
				`OFS_SERIAL_SLAVE_ADDRESS:
				begin
					if (mask_access)
						state_d.serial_address_mask = wr_data_i;
					else
						state_d.serial_slave_address = wr_data_i;
				end
				`OFS_SERIAL_PORT_STATUS:    state_d.serial_port_status = wr_data_i & `MSK_SERIAL_STATUS_WR;
				`OFS_PORT_B_WEAK_PULLUP:    state_d.port_b_weak_pullup = wr_data_i;
				`OFS_PORT_A_LATCH:          state_d.port_a_latch = wr_data_i;
				`OFS_PORT_B_LATCH:          state_d.port_b_latch = wr_data_i;
				`OFS_PORT_C_LATCH:          state_d.port_c_latch = wr_data_i;
				`OFS_PORT_D_LATCH:          state_d.port_d_latch = wr_data_i;
				`OFS_PORT_E_LATCH:          state_d.port_e_latch = wr_data_i & `MSK_PORT_E;
				`OFS_ANALOG_SELECT_LOW:     state_d.analog_select_low = wr_data_i;
				`OFS_ANALOG_SELECT_HIGH:    state_d.analog_select_high = wr_data_i;
				`OFS_SERIAL_PORT_CONTROL:   state_d.serial_port_control = wr_data_i;
				`OFS_IRQ_STATUS:            state_d.irq_status = state_q.irq_status & ~wr_data_i;
				`OFS_IRQ_MASK:              state_d.irq_mask = wr_data_i & `MSK_IRQ;
				default:                    state_d.rd_data = state_q.rd_data;
			endcase
		end

		// Reading the port-B pins re-arms the change detector
		if (rd_en_i && (addr_i == `OFS_PORT_B_PINS))
			state_d.port_b_snapshot = port_b_digital;

		// The hardware set wins over a software clear in the same cycle
		if (mismatch)
			state_d.interrupt_control[`BIT_PORT_B_CHANGE_FLAG] = 1'b1;
		if (state_d.interrupt_control[`BIT_PORT_B_CHANGE_FLAG] && !flag_now)
			state_d.irq_status[`IRQ_BIT_PORT_B_CHANGE] = 1'b1;

		// Read data, one cycle after the strobe
		state_d.rd_data = 8'h00;
		if (rd_en_i)
		begin
			case (addr_i)
				`OFS_INDIRECT_ACCESS_PORT:  state_d.rd_data = dmem_rdata_i;
				`OFS_PRESCALER_EDGE_CONFIG: state_d.rd_data = state_q.prescaler_edge_config;
				`OFS_PROGRAM_COUNTER_LOW:   state_d.rd_data = state_q.program_counter_low;
				`OFS_ALU_FLAGS_BANK_SELECT: state_d.rd_data = {state_q.alu_flags_bank_select[7:5], timeout_flag_i,
					powerdown_flag_i, state_q.alu_flags_bank_select[2:0]};
				`OFS_INDIRECT_POINTER:      state_d.rd_data = state_q.indirect_pointer;
				`OFS_PORT_A_DIRECTION:      state_d.rd_data = state_q.port_a_direction;
				`OFS_PORT_B_DIRECTION:      state_d.rd_data = state_q.port_b_direction;
				`OFS_PORT_C_DIRECTION:      state_d.rd_data = state_q.port_c_direction;
				`OFS_PORT_D_DIRECTION:      state_d.rd_data = state_q.port_d_direction;
				`OFS_PORT_E_DIRECTION:      state_d.rd_data = state_q.port_e_direction;
				`OFS_PC_HIGH_LATCH:         state_d.rd_data = state_q.program_counter_high_latch;
				`OFS_INTERRUPT_CONTROL:     state_d.rd_data = state_q.interrupt_control;
				`OFS_PERIPH_IRQ_ENABLE_1:   state_d.rd_data = state_q.peripheral_irq_enable_1;
				`OFS_PERIPH_IRQ_ENABLE_2:   state_d.rd_data = state_q.peripheral_irq_enable_2;
				`OFS_POWER_CONTROL:         state_d.rd_data = state_q.power_control;
				`OFS_OSCILLATOR_CONTROL:    state_d.rd_data = state_q.oscillator_control | {4'h0, osc_status_i, 1'b0};
				`OFS_OSCILLATOR_TUNING:     state_d.rd_data = state_q.oscillator_tuning;
				`OFS_SERIAL_PORT_CONTROL_2: state_d.rd_data = state_q.serial_port_control_2;
				`OFS_TIMER2_PERIOD:         state_d.rd_data = state_q.timer2_period;
				`OFS_SERIAL_SLAVE_ADDRESS:  state_d.rd_data = mask_access ? state_q.serial_address_mask
					: state_q.serial_slave_address;
				`OFS_SERIAL_PORT_STATUS:    state_d.rd_data = {state_q.serial_port_status[7:6], serial_status_i};
				`OFS_PORT_B_WEAK_PULLUP:    state_d.rd_data = state_q.port_b_weak_pullup;
				`OFS_PORT_A_LATCH:          state_d.rd_data = state_q.port_a_latch;
				`OFS_PORT_B_LATCH:          state_d.rd_data = state_q.port_b_latch;
				`OFS_PORT_C_LATCH:          state_d.rd_data = state_q.port_c_latch;
				`OFS_PORT_D_LATCH:          state_d.rd_data = state_q.port_d_latch;
				`OFS_PORT_E_LATCH:          state_d.rd_data = state_q.port_e_latch;
				`OFS_ANALOG_SELECT_LOW:     state_d.rd_data = state_q.analog_select_low;
				`OFS_ANALOG_SELECT_HIGH:    state_d.rd_data = state_q.analog_select_high;
				`OFS_SERIAL_PORT_CONTROL:   state_d.rd_data = state_q.serial_port_control;
				`OFS_IRQ_STATUS:            state_d.rd_data = state_q.irq_status;
				`OFS_IRQ_MASK:              state_d.rd_data = state_q.irq_mask;
				`OFS_PORT_A_PINS:           state_d.rd_data = port_read(port_a_pins_i, state_q.analog_select_low);
				`OFS_PORT_B_PINS:           state_d.rd_data = port_b_digital;
				`OFS_PORT_C_PINS:           state_d.rd_data = port_c_pins_i;
				`OFS_PORT_D_PINS:           state_d.rd_data = port_d_pins_i;
				`OFS_PORT_E_PINS:           state_d.rd_data = port_e_pins_i & `MSK_PORT_E;
				default:                    state_d.rd_data = 8'h00;
			endcase
		end

		// Any reset: the registers below take their listed values; latches, snapshot, IRQ status and mask and power control depend on the cause
		if (!rst_n_i)
		begin
			state_d.prescaler_edge_config      = `RST_PRESCALER_EDGE_CONFIG;
			state_d.program_counter_low        = `RST_PROGRAM_COUNTER_LOW;
			state_d.alu_flags_bank_select      = `RST_ALU_FLAGS_BANK_SELECT;
			state_d.indirect_pointer           = `RST_INDIRECT_POINTER;
			state_d.port_a_direction           = `RST_PORT_DIRECTION;
			state_d.port_b_direction           = `RST_PORT_DIRECTION;
			state_d.port_c_direction           = `RST_PORT_DIRECTION;
			state_d.port_d_direction           = `RST_PORT_DIRECTION;
			state_d.port_e_direction           = `RST_PORT_E_DIRECTION;
			state_d.program_counter_high_latch = `RST_PC_HIGH_LATCH;
			state_d.interrupt_control          = `RST_INTERRUPT_CONTROL;
			state_d.peripheral_irq_enable_1    = `RST_PERIPH_IRQ_ENABLE;
			state_d.peripheral_irq_enable_2    = `RST_PERIPH_IRQ_ENABLE;
			state_d.oscillator_control         = `RST_OSCILLATOR_CONTROL;
			state_d.oscillator_tuning          = `RST_OSCILLATOR_TUNING;
			state_d.serial_port_control_2      = `RST_SERIAL_PORT_CONTROL_2;
			state_d.timer2_period              = `RST_TIMER2_PERIOD;
			state_d.serial_slave_address       = `RST_SERIAL_SLAVE_ADDRESS;
			state_d.serial_address_mask        = `RST_SERIAL_ADDRESS_MASK;
			state_d.serial_port_status         = `RST_SERIAL_PORT_STATUS;
			state_d.port_b_weak_pullup         = `RST_PORT_B_WEAK_PULLUP;
			state_d.analog_select_low          = `RST_ANALOG_SELECT;
			state_d.analog_select_high         = `RST_ANALOG_SELECT;
			state_d.serial_port_control        = `RST_SERIAL_PORT_CONTROL;
			state_d.rd_data                    = 8'h00;
			if (reset_por_i || reset_bor_i)
			begin
				// Power flags record which supply event caused the reset
				state_d.power_control = reset_por_i ? `RST_POWER_CONTROL_POR : `RST_POWER_CONTROL_BOR;
				state_d.port_a_latch    = `RST_PORT_LATCH;
				state_d.port_b_latch    = `RST_PORT_LATCH;
				state_d.port_c_latch    = `RST_PORT_LATCH;
				state_d.port_d_latch    = `RST_PORT_LATCH;
				state_d.port_e_latch    = `RST_PORT_LATCH;
				state_d.port_b_snapshot = `RST_PORT_LATCH;
				state_d.irq_status      = `RST_IRQ;
				state_d.irq_mask        = `RST_IRQ;
			end
			else
			begin
				// Clear or watchdog reset: latches, snapshot and power flags survive
				state_d.power_control = (state_q.power_control & `MSK_POWER_FLAGS)
					| (`RST_POWER_CONTROL_POR & ~`MSK_POWER_FLAGS);
				state_d.irq_status[`IRQ_BIT_WARM_RESET] = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		state_q <= state_d;
	end

	assign rd_data_o                = state_q.rd_data;
	assign port_a_direction_o       = state_q.port_a_direction;
	assign port_b_direction_o       = state_q.port_b_direction;
	assign port_c_direction_o       = state_q.port_c_direction;
	assign port_d_direction_o       = state_q.port_d_direction;
	assign port_e_direction_o       = state_q.port_e_direction;
	assign port_a_latch_o           = state_q.port_a_latch;
	assign port_b_latch_o           = state_q.port_b_latch;
	assign port_c_latch_o           = state_q.port_c_latch;
	assign port_d_latch_o           = state_q.port_d_latch;
	assign port_e_latch_o           = state_q.port_e_latch;
	assign port_b_weak_pullup_o     = state_q.port_b_weak_pullup;
	assign prescaler_edge_config_o  = state_q.prescaler_edge_config;
	assign interrupt_control_o      = state_q.interrupt_control;
	assign timer2_period_o          = state_q.timer2_period;
	assign serial_slave_address_o   = state_q.serial_slave_address;
	assign serial_address_mask_o    = state_q.serial_address_mask;
	assign serial_port_mode_field_o = state_q.serial_port_control[3:0];
	assign irq_o                    = |(state_q.irq_status & state_q.irq_mask);

endmodule // sfr_bank1_decode

// ===== design/sfr_bank1_decode_defines.svh
// Offsets, field positions, reset values and masks of the bank-one register decoder
// Overview of operation
// - Offset 80h reaches memory through the pointer
// - Mode 1001 redirects 93h to mask register
// - Clear and watchdog resets keep port latches
// - Reset clears port-B change flag, mismatch sets it again
// - Analog-selected pins read zero after reset
// - Unimplemented bits read zero, ignore writes
`ifndef SFR_BANK1_DECODE_DEFINES_SVH
`define SFR_BANK1_DECODE_DEFINES_SVH

`define OFS_INDIRECT_ACCESS_PORT  8'h80
`define OFS_PRESCALER_EDGE_CONFIG 8'h81
`define OFS_PROGRAM_COUNTER_LOW   8'h82
`define OFS_ALU_FLAGS_BANK_SELECT 8'h83
`define OFS_INDIRECT_POINTER      8'h84
`define OFS_PORT_A_DIRECTION      8'h85
`define OFS_PORT_B_DIRECTION      8'h86
`define OFS_PORT_C_DIRECTION      8'h87
`define OFS_PORT_D_DIRECTION      8'h88
`define OFS_PORT_E_DIRECTION      8'h89
`define OFS_PC_HIGH_LATCH         8'h8A
`define OFS_INTERRUPT_CONTROL     8'h8B
`define OFS_PERIPH_IRQ_ENABLE_1   8'h8C
`define OFS_PERIPH_IRQ_ENABLE_2   8'h8D
`define OFS_POWER_CONTROL         8'h8E
`define OFS_OSCILLATOR_CONTROL    8'h8F
`define OFS_OSCILLATOR_TUNING     8'h90
`define OFS_SERIAL_PORT_CONTROL_2 8'h91
`define OFS_TIMER2_PERIOD         8'h92
`define OFS_SERIAL_SLAVE_ADDRESS  8'h93
`define OFS_SERIAL_PORT_STATUS    8'h94
`define OFS_PORT_B_WEAK_PULLUP    8'h95
`define OFS_PORT_A_LATCH          8'hA0
`define OFS_PORT_B_LATCH          8'hA1
`define OFS_PORT_C_LATCH          8'hA2
`define OFS_PORT_D_LATCH          8'hA3
`define OFS_PORT_E_LATCH          8'hA4
`define OFS_ANALOG_SELECT_LOW     8'hA5
`define OFS_ANALOG_SELECT_HIGH    8'hA6
`define OFS_SERIAL_PORT_CONTROL   8'hA7
`define OFS_IRQ_STATUS            8'hA8
`define OFS_IRQ_MASK              8'hA9
`define OFS_PORT_A_PINS           8'hB0
`define OFS_PORT_B_PINS           8'hB1
`define OFS_PORT_C_PINS           8'hB2
`define OFS_PORT_D_PINS           8'hB3
`define OFS_PORT_E_PINS           8'hB4

`define RST_PRESCALER_EDGE_CONFIG 8'hFF
`define RST_PROGRAM_COUNTER_LOW   8'h00
`define RST_ALU_FLAGS_BANK_SELECT 8'h18
`define RST_INDIRECT_POINTER      8'h00
`define RST_PORT_DIRECTION        8'hFF
`define RST_PORT_E_DIRECTION      8'h0F
`define RST_PC_HIGH_LATCH         8'h00
`define RST_INTERRUPT_CONTROL     8'h00
`define RST_PERIPH_IRQ_ENABLE     8'h00
`define RST_POWER_CONTROL_POR     8'h10
`define RST_POWER_CONTROL_BOR     8'h12
`define RST_OSCILLATOR_CONTROL    8'h60
`define RST_OSCILLATOR_TUNING     8'h00
`define RST_SERIAL_PORT_CONTROL_2 8'h00
`define RST_TIMER2_PERIOD         8'hFF
`define RST_SERIAL_SLAVE_ADDRESS  8'h00
`define RST_SERIAL_ADDRESS_MASK   8'hFF
`define RST_SERIAL_PORT_STATUS    8'h00
`define RST_PORT_B_WEAK_PULLUP    8'hFF
`define RST_PORT_LATCH            8'h00
`define RST_ANALOG_SELECT         8'hFF
`define RST_SERIAL_PORT_CONTROL   8'h00
`define RST_IRQ                   8'h00

`define MSK_ALU_FLAGS_WR          8'hE7
`define MSK_PC_HIGH_LATCH         8'h1F
`define MSK_PORT_E                8'h0F
`define MSK_PERIPH_IRQ_ENABLE_1   8'h7F
`define MSK_PERIPH_IRQ_ENABLE_2   8'hFD
`define MSK_POWER_CONTROL         8'h33
`define MSK_POWER_FLAGS           8'h03
`define MSK_OSCILLATOR_CONTROL_WR 8'h71
`define MSK_OSCILLATOR_TUNING     8'h1F
`define MSK_SERIAL_STATUS_WR      8'hC0
`define MSK_IRQ                   8'h03

`define BIT_PORT_B_CHANGE_FLAG    0
`define BIT_INDIRECT_BANK         7
`define SERIAL_MODE_MASK_ACCESS   4'h9
`define IRQ_BIT_PORT_B_CHANGE     0
`define IRQ_BIT_WARM_RESET        1

`endif

// ===== design/sfr_bank1_decode_pkg.sv
// Types of the bank-one register decoder
package sfr_bank1_decode_pkg;

	typedef struct packed {
		logic [7:0] prescaler_edge_config;
		logic [7:0] program_counter_low;
		logic [7:0] alu_flags_bank_select;
		logic [7:0] indirect_pointer;
		logic [7:0] port_a_direction;
		logic [7:0] port_b_direction;
		logic [7:0] port_c_direction;
		logic [7:0] port_d_direction;
		logic [7:0] port_e_direction;
		logic [7:0] program_counter_high_latch;
		logic [7:0] interrupt_control;
		logic [7:0] peripheral_irq_enable_1;
		logic [7:0] peripheral_irq_enable_2;
		logic [7:0] power_control;
		logic [7:0] oscillator_control;
		logic [7:0] oscillator_tuning;
		logic [7:0] serial_port_control_2;
		logic [7:0] timer2_period;
		logic [7:0] serial_slave_address;
		logic [7:0] serial_address_mask;
		logic [7:0] serial_port_status;
		logic [7:0] port_b_weak_pullup;
		logic [7:0] port_a_latch;
		logic [7:0] port_b_latch;
		logic [7:0] port_c_latch;
		logic [7:0] port_d_latch;
		logic [7:0] port_e_latch;
		logic [7:0] analog_select_low;
		logic [7:0] analog_select_high;
		logic [7:0] serial_port_control;
		logic [7:0] port_b_snapshot;
		logic [7:0] irq_status;
		logic [7:0] irq_mask;
		logic [7:0] rd_data;
	} state_type;

endpackage

// ===== bench/sfr_bank1_decode_assertions.sv
// Port-level assertions of the bank-one register decoder
`timescale 1ns/1ps
module sfr_bank1_decode_checker (
	// Clock, reset and register port
	input wire logic       core_clk_i,
	input wire logic       rst_n_i,
	input wire logic       reset_por_i,
	input wire logic       reset_bor_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wr_data_i,
	input wire logic       wr_en_i,
	input wire logic       rd_en_i,
	input wire logic [7:0] rd_data_o,
	// Memory reached through the pointer
	input wire logic [8:0] dmem_addr_o,
	input wire logic [7:0] dmem_wdata_o,
	input wire logic       dmem_we_o,
	input wire logic       dmem_re_o,
	input wire logic [7:0] dmem_rdata_i,
	// Register outputs
	input wire logic [7:0] port_a_latch_o,
	input wire logic [7:0] port_e_direction_o,
	input wire logic [7:0] interrupt_control_o,
	input wire logic [7:0] timer2_period_o,
	input wire logic [7:0] serial_slave_address_o,
	input wire logic [7:0] serial_address_mask_o,
	input wire logic [3:0] serial_port_mode_field_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	a_indirect_write: assert property (disable iff (!rst_n_i) wr_en_i && addr_i == 8'h80 |-> dmem_we_o && dmem_wdata_o == wr_data_i)
		else $error("indirect write not passed to memory");
	a_indirect_read: assert property (disable iff (!rst_n_i) rd_en_i && addr_i == 8'h80 |-> dmem_re_o ##1 rd_data_o == $past(dmem_rdata_i))
		else $error("indirect read data wrong");
	a_pointer_addr: assert property (disable iff (!rst_n_i) wr_en_i && addr_i == 8'h84 |=> dmem_addr_o[7:0] == $past(wr_data_i))
		else $error("memory address does not follow pointer");
	a_alias_mask: assert property (disable iff (!rst_n_i) wr_en_i && addr_i == 8'h93 && serial_port_mode_field_o == 4'h9
		|=> serial_address_mask_o == $past(wr_data_i) && $stable(serial_slave_address_o))
		else $error("aliased write missed mask register");
	a_alias_off: assert property (disable iff (!rst_n_i) wr_en_i && addr_i == 8'h93 && serial_port_mode_field_o != 4'h9
		|=> serial_slave_address_o == $past(wr_data_i) && $stable(serial_address_mask_o))
		else $error("plain write missed slave address");
	// No disable here: these guard what the reset itself does
	a_latch_kept: assert property (!rst_n_i && !reset_por_i && !reset_bor_i |=> $stable(port_a_latch_o))
		else $error("port latch lost in warm reset");
	a_flag_reset: assert property (!rst_n_i |=> interrupt_control_o[0] == 1'b0)
		else $error("change flag not cleared in reset");
	a_unmapped_read: assert property (disable iff (!rst_n_i) rd_en_i && addr_i == 8'h96 |=> rd_data_o == 8'h00)
		else $error("unmapped read not zero");
	a_dir_e_upper: assert property (disable iff (!rst_n_i) port_e_direction_o[7:4] == 4'h0)
		else $error("unimplemented direction bits set");
	a_por_values: assert property (!rst_n_i && reset_por_i |=> timer2_period_o == 8'hFF && port_a_latch_o == 8'h00)
		else $error("power-on values not loaded");
endmodule // sfr_bank1_decode_checker

bind sfr_bank1_decode sfr_bank1_decode_checker chk_u (.core_clk_i, .rst_n_i, .reset_por_i, .reset_bor_i, .addr_i,
	.wr_data_i, .wr_en_i, .rd_en_i, .rd_data_o, .dmem_addr_o, .dmem_wdata_o, .dmem_we_o, .dmem_re_o, .dmem_rdata_i,
	.port_a_latch_o, .port_e_direction_o, .interrupt_control_o, .timer2_period_o, .serial_slave_address_o,
	.serial_address_mask_o, .serial_port_mode_field_o);

// ===== bench/tb_sfr_bank1_decode.sv
// Self-checking bench of the bank-one register decoder
`timescale 1ns/1ps
module tb_sfr_bank1_decode;
	logic       core_clk_i, rst_n_i, reset_por_i, reset_bor_i, wr_en_i, rd_en_i, dmem_we_o, dmem_re_o, irq_o;
	logic       timeout_flag_i, powerdown_flag_i;
	logic [7:0] addr_i, wr_data_i, rd_data_o, dmem_wdata_o, dmem_rdata_i, port_a_latch_o, interrupt_control_o;
	logic [7:0] port_a_pins_i, port_b_pins_i, port_c_pins_i, port_d_pins_i, port_e_pins_i;
	logic [7:0] serial_slave_address_o, serial_address_mask_o;
	logic [8:0] dmem_addr_o;
	logic [3:0] serial_port_mode_field_o;
	int         n_fail, comparisons, cycles;
	logic [15:0] rst_tbl [0:20] = '{16'h81FF, 16'h8200, 16'h8310, 16'h8400, 16'h85FF, 16'h86FF, 16'h87FF, 16'h88FF,
		16'h890F, 16'h8A00, 16'h8B00, 16'h8C00, 16'h8D00, 16'h8E10, 16'h8F6A, 16'h9000, 16'h9100, 16'h92FF,
		16'h9300, 16'h9415, 16'h95FF};

	sfr_bank1_decode dut_u (.core_clk_i, .rst_n_i, .reset_por_i, .reset_bor_i, .addr_i, .wr_data_i, .wr_en_i,
		.rd_en_i, .rd_data_o, .dmem_addr_o, .dmem_wdata_o, .dmem_we_o, .dmem_re_o, .dmem_rdata_i, .timeout_flag_i,
		.powerdown_flag_i, .osc_status_i(3'h5), .serial_status_i(6'h15), .port_a_pins_i, .port_b_pins_i,
		.port_c_pins_i, .port_d_pins_i, .port_e_pins_i, .port_a_direction_o(), .port_b_direction_o(),
		.port_c_direction_o(), .port_d_direction_o(), .port_e_direction_o(), .port_a_latch_o, .port_b_latch_o(),
		.port_c_latch_o(), .port_d_latch_o(), .port_e_latch_o(), .port_b_weak_pullup_o(),
		.prescaler_edge_config_o(), .interrupt_control_o, .timer2_period_o(), .serial_slave_address_o,
		.serial_address_mask_o, .serial_port_mode_field_o, .irq_o);

	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		addr_i <= a;
		wr_data_i <= d;
		wr_en_i <= 1'b1;
		@(posedge core_clk_i);
		wr_en_i <= 1'b0;
		#1;
	endtask

	// Read data is looked at only in the one cycle it stands
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
		@(posedge core_clk_i);
		addr_i <= a;
		rd_en_i <= 1'b1;
		@(posedge core_clk_i);
		rd_en_i <= 1'b0;
		#1;
		chk(name, rd_data_o, exp);
	endtask

	task automatic do_reset(input logic por, input logic bor);
		@(posedge core_clk_i);
		rst_n_i <= 1'b0;
		reset_por_i <= por;
		reset_bor_i <= bor;
		repeat (16) @(posedge core_clk_i);
		#1;
		chk("flag in reset", {7'h00, interrupt_control_o[0]}, 8'h00);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge core_clk_i);
		#1;
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial
	begin
		core_clk_i = 1'b0;
		forever #4 core_clk_i = ~core_clk_i;
	end

	// Ceiling well above the roughly 160 cycles the tests need
	always @(posedge core_clk_i)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_fail++;
			summarize();
		end
	end

	initial
	begin
		{rst_n_i, reset_por_i, reset_bor_i, wr_en_i, rd_en_i, addr_i, wr_data_i} = '0;
		// Power-on cause from time zero, so the first reset edge is never taken as a warm reset
		{timeout_flag_i, powerdown_flag_i, reset_por_i, dmem_rdata_i, port_a_pins_i, port_b_pins_i} = {3'b101, 24'h0};
		{port_c_pins_i, port_d_pins_i, port_e_pins_i} = 24'h0;
		do_reset(1'b1, 1'b0);
		foreach (rst_tbl[i]) rd(rst_tbl[i][15:8], rst_tbl[i][7:0], "reset value");
		{timeout_flag_i, powerdown_flag_i} <= 2'b01;
		rd(8'h83, 8'h08, "flag inputs");
		$display("test reset values done");
		rd(8'h96, 8'h00, "unmapped");
		wr(8'h96, 8'h55);
		rd(8'h96, 8'h00, "unmapped after write");
		wr(8'h89, 8'hFF);
		rd(8'h89, 8'h0F, "port e direction");
		$display("test unimplemented done");
		wr(8'h84, 8'h3C);
		chk("memory address", dmem_addr_o[7:0], 8'h3C);
		wr(8'h80, 8'h77);
		dmem_rdata_i <= 8'hA5;
		rd(8'h80, 8'hA5, "indirect read");
		rd(8'h84, 8'h3C, "pointer kept");
		$display("test indirect done");
		wr(8'hA7, 8'h09);
		wr(8'h93, 8'h5A);
		chk("mask", serial_address_mask_o, 8'h5A);
		chk("slave address", serial_slave_address_o, 8'h00);
		rd(8'h93, 8'h5A, "aliased read");
		wr(8'hA7, 8'h08);
		wr(8'h93, 8'h33);
		rd(8'h93, 8'h33, "plain read");
		chk("mask kept", serial_address_mask_o, 8'h5A);
		$display("test alias done");
		wr(8'hA0, 8'h5A);
		wr(8'hA5, 8'h00);
		wr(8'hA9, 8'h01);
		port_a_pins_i <= 8'hC3;
		port_b_pins_i <= 8'h0F;
		rd(8'hB0, 8'hC3, "digital port a");
		wr(8'hA6, 8'h00);
		// The flag and its status bit land one edge after the mismatch appears
		@(posedge core_clk_i);
		#1;
		chk("irq raised", {7'h00, irq_o}, 8'h01);
		wr(8'hA8, 8'h01);
		chk("irq cleared", {7'h00, irq_o}, 8'h00);
		rd(8'hB1, 8'h0F, "digital port b");
		do_reset(1'b0, 1'b0);
		chk("flag after reset", {7'h00, interrupt_control_o[0]}, 8'h01);
		chk("latch kept", port_a_latch_o, 8'h5A);
		rd(8'hB0, 8'h00, "analog port a");
		rd(8'hB1, 8'h00, "analog port b");
		rd(8'hA8, 8'h03, "irq status");
		chk("irq masked in", {7'h00, irq_o}, 8'h01);
		wr(8'hA9, 8'h00);
		chk("irq masked out", {7'h00, irq_o}, 8'h00);
		$display("test warm reset done");
		do_reset(1'b0, 1'b1);
		rd(8'h8E, 8'h12, "brown-out power");
		chk("latch cleared", port_a_latch_o, 8'h00);
		$display("test brown-out done");
		summarize();
	end
endmodule // tb_sfr_bank1_decode
